// >>> tct_counter.sv
// one 16-bit down counter channel with six modes, latch and status
`timescale 1ns/10ps
`default_nettype none
module tct_counter
  import tct_pkg::*;
(
  input  wire logic              mclk_i,
  input  wire logic              rst_i,
  input  wire logic              tick_i,    // clock pulse seen, one cycle
  input  wire logic              gate_i,    // synchronised gate level
  input  wire logic              cfg_we_i,  // setup byte for this counter
  input  wire tct_pkg::tct_cfg_t cfg_i,
  input  wire logic              latch_i,   // count latch request
  input  wire logic              stlat_i,   // status latch request
  input  wire tct_pkg::tct_hacc_t hacc_i,
  output logic [7:0]             rdata_o,
  output logic                   out_o
);
  import tct_pkg::*;

  tct_cfg_t    cfg_q;
  logic [15:0] cnt_q, init_q, hold_q;
  logic [7:0]  lsb_q, stat_q;
  logic        hold_v_q, hold_hi_q, stat_v_q, wr_hi_q, rd_hi_q;
  logic        null_q, armed_q, run_q, gate_q, trig_q, half_q;

  // decoded mode, bit 2 ignored for modes 2 and 3
  wire [2:0] mraw = cfg_q.mode_raw;
  wire [2:0] mode = mraw[1] ? {1'b0, mraw[1:0]} : mraw;
  wire gate_rise = gate_i & ~gate_q;
  wire load_done = hacc_i.wr & ((cfg_q.acc != TCT_ACC_PAIR) | wr_hi_q);
  wire [15:0] wval = (cfg_q.acc == TCT_ACC_MSB) ? {hacc_i.data, 8'h00} :
                     (cfg_q.acc == TCT_ACC_LSB) ? {8'h00, hacc_i.data} :
                                                  {hacc_i.data, lsb_q};
  // gate governs counting in modes 0, 2, 3 and 4
  wire gate_ok = (mode == TCT_M1 || mode == TCT_M5) ? 1'b1 : gate_i;
  wire step = tick_i & run_q & gate_ok;
  wire [15:0] dec  = (mode == TCT_M3) ? 16'(cnt_q - TCT_CNT_TWO)
                                      : 16'(cnt_q - TCT_CNT_ONE);
  // bcd decrement by one per digit borrow
  function automatic logic [15:0] bcd_dec(input logic [15:0] v);
    logic [15:0] r;
    logic        br;
    r  = v;
    br = 1'b1;
    for (int d = 0; d < 4; d++) begin
      if (br) begin
        if (v[d*4 +: 4] == 4'h0) begin
          r[d*4 +: 4] = 4'h9;
        end else begin
          r[d*4 +: 4] = 4'(v[d*4 +: 4] - 4'h1);
          br = 1'b0;
        end
      end
    end
    return r;
  endfunction
  wire [15:0] nxt = cfg_q.bcd ? ((mode == TCT_M3) ? bcd_dec(bcd_dec(cnt_q))
                                                   : bcd_dec(cnt_q)) : dec;
  // odd count: the high half runs on to zero, one count longer than the low half
  wire at_end = (mode == TCT_M3) ? ((half_q && init_q[0]) ? (cnt_q == TCT_CNT_ZERO)
                                                          : (cnt_q <= TCT_CNT_TWO))
                                 : (cnt_q == TCT_CNT_ONE);
  wire [15:0] init_m3 = {init_q[15:1], 1'b0};  // even part of the count
  wire [7:0]  sbyte = {out_o, null_q, cfg_q.acc, cfg_q.mode_raw, cfg_q.bcd};

  // read data: status first, then held count, else live count
  // combinational, so a back-to-back read already sees the advanced byte toggle
  always_comb begin
    if (stat_v_q) begin
      rdata_o = stat_q;
    end else if (hold_v_q) begin
      rdata_o = hold_hi_q ? hold_q[15:8] : hold_q[7:0];
    end else begin
      rdata_o = (rd_hi_q || cfg_q.acc == TCT_ACC_MSB) ? cnt_q[15:8] : cnt_q[7:0];
    end
  end

  // host side: setup, load, latch, read sequencing
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cfg_q <= '{acc: TCT_ACC_LSB, mode_raw: 3'h0, bcd: 1'b0};
      init_q <= TCT_CNT_ZERO;
      lsb_q <= 8'h00;
      hold_q <= TCT_CNT_ZERO;
      stat_q <= 8'h00;
      {hold_v_q, hold_hi_q, stat_v_q, wr_hi_q, rd_hi_q, null_q} <= '0;
    end else begin
      if (cfg_we_i) begin
        cfg_q <= cfg_i;
        {wr_hi_q, rd_hi_q, null_q} <= 3'b001;
      end
      if (latch_i && !hold_v_q) begin  // repeat latch ignored
        hold_q    <= cnt_q;
        hold_v_q  <= 1'b1;
        hold_hi_q <= (cfg_q.acc == TCT_ACC_MSB);
      end
      if (stlat_i && !stat_v_q) begin
        stat_q   <= sbyte;
        stat_v_q <= 1'b1;
      end
      if (hacc_i.wr) begin
        if (cfg_q.acc == TCT_ACC_PAIR) begin  // low then high
          wr_hi_q <= ~wr_hi_q;
          lsb_q   <= hacc_i.data;
        end
        if (load_done) begin
          init_q <= wval;
          null_q <= 1'b1;
        end
      end
      if (tick_i && null_q && !load_done) begin
        null_q <= 1'b0;
      end
      if (hacc_i.rd) begin
        if (stat_v_q) begin
          stat_v_q <= 1'b0;
        end else if (hold_v_q) begin
          if (cfg_q.acc == TCT_ACC_PAIR && !hold_hi_q) begin
            hold_hi_q <= 1'b1;
          end else begin
            hold_v_q <= 1'b0;
          end
        end else if (cfg_q.acc == TCT_ACC_PAIR) begin
          rd_hi_q <= ~rd_hi_q;
        end
      end
    end
  end

  // count engine per mode
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cnt_q <= TCT_CNT_ZERO;
      out_o <= 1'b1;
      {armed_q, run_q, gate_q, trig_q, half_q} <= '0;
    end else begin
      gate_q <= gate_i;
      if (cfg_we_i) begin
        out_o <= (cfg_i.mode_raw == 3'h0) ? 1'b0 : 1'b1;
        {armed_q, run_q, trig_q} <= '0;
      end else if (load_done) begin
        armed_q <= 1'b1;
        trig_q  <= 1'b0;
        if (mode == TCT_M0) begin
          out_o <= 1'b0;
        end
      end else if (armed_q && tick_i) begin
        // pending count moves into the counter on the next clock pulse
        armed_q <= 1'b0;
        cnt_q   <= (mode == TCT_M3) ? init_m3 : init_q;
        half_q  <= 1'b1;
        run_q   <= (mode == TCT_M0 || mode == TCT_M1 || mode == TCT_M5)
                   ? trig_q : 1'b1;
        if (mode == TCT_M1 && trig_q) begin
          out_o <= 1'b0;
        end
        trig_q <= 1'b0;
      end else begin
        if (gate_rise) begin
          trig_q <= 1'b1;
          if (!armed_q && (mode == TCT_M1 || mode == TCT_M5 || mode == TCT_M0)) begin
            armed_q <= 1'b1;       // retrigger reloads full count
          end
          if (mode == TCT_M2 || mode == TCT_M3) begin
            armed_q <= 1'b1;
            out_o   <= 1'b1;
          end
        end
        if ((mode == TCT_M2 || mode == TCT_M3) && !gate_i) begin
          out_o <= 1'b1;           // low gate stops the waveform
        end
        if (step) begin
          cnt_q <= nxt;
          if (mode == TCT_M2 && cnt_q == TCT_CNT_TWO) begin
            out_o <= 1'b0;         // one clock low
          end else if (mode == TCT_M2 && at_end) begin
            out_o <= 1'b1;
            cnt_q <= init_q;
          end else if (mode == TCT_M3 && at_end) begin
            // half done: flip output and reload the even part
            out_o  <= ~out_o;
            half_q <= ~half_q;
            cnt_q  <= init_m3;
          end else if (at_end) begin
            run_q <= 1'b0;
            if (mode == TCT_M4 || mode == TCT_M5) begin
              out_o <= 1'b0;       // strobe
            end else begin
              out_o <= 1'b1;
            end
          end
        end else if (tick_i && !out_o && (mode == TCT_M4 || mode == TCT_M5)) begin
          out_o <= 1'b1;
        end
      end
    end
  end

  mode4_strobe_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (mode == TCT_M4 && step && at_end && !cfg_we_i && !load_done && !armed_q)
      |=> !out_o) else $error("mode 4 strobe missing");
  mode0_load_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (mode == TCT_M0 && load_done && !cfg_we_i) |=> !out_o)
    else $error("mode 0 load left output high");
  latch_hold_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (hold_v_q && !hacc_i.rd) |=> $stable(hold_q))
    else $error("held count changed before read");
endmodule
`default_nettype wire

// >>> tct_host_model.sv
// host bus model: byte writes and reads toward the timer block
`timescale 1ns/10ps
`default_nettype none
module tct_host_model (
  input  wire logic       mclk_i,
  input  wire logic [7:0] rdata_i,
  output var  logic [3:0] addr_o,
  output var  logic       wr_o,
  output var  logic       rd_o,
  output var  logic [7:0] wdata_o
);
  // idle bus parked on scrambled values, strobes low
  initial begin
    addr_o  = 4'h5;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
    wdata_o = 8'ha5;
  end
  // one write; bus inverted after so a stale byte never looks valid
  task automatic wr8(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    #1;
    addr_o  = a;
    wdata_o = d;
    wr_o    = 1'b1;
    @(posedge mclk_i);
    #1;
    wr_o    = 1'b0;
    addr_o  = ~a;
    wdata_o = ~d;
  endtask
  // one read; byte is registered at the taking edge
  task automatic rd8(input logic [3:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    #1;
    addr_o = a;
    rd_o   = 1'b1;
    @(posedge mclk_i);
    #1;
    rd_o   = 1'b0;
    addr_o = ~a;
    d      = rdata_i;
  endtask
  // setup byte: select, access order, mode bits, bcd bit at the bottom
  task automatic setup(input logic [1:0] sel, input logic [1:0] acc,
                       input logic [2:0] md, input logic bcd);
    wr8(4'h3, {sel, acc, md, bcd});
  endtask
  // two-byte loads always go low then high
  task automatic load16(input logic [3:0] a, input logic [15:0] v);
    wr8(a, v[7:0]);
    wr8(a, v[15:8]);
  endtask
endmodule
`default_nettype wire

// >>> tct_pkg.sv
// package for the triple counter timer block: offsets, fields, modes, carriers
package tct_pkg;

  // ****************************************
  // host offsets
  // ****************************************
  localparam logic [3:0] TCT_OFS_CNT0   = 4'h0;
  localparam logic [3:0] TCT_OFS_CNT2   = 4'h2;
  localparam logic [3:0] TCT_OFS_SETUP  = 4'h3;
  localparam logic [3:0] TCT_OFS_MAPSEL = 4'hd;

  // ****************************************
  // setup byte fields
  // ****************************************
  localparam int TCT_SEL_HI = 7;
  localparam int TCT_SEL_LO = 6;
  localparam int TCT_ACC_HI = 5;
  localparam int TCT_ACC_LO = 4;
  localparam int TCT_MOD_HI = 3;
  localparam int TCT_MOD_LO = 1;
  localparam int TCT_BCD    = 0;
  localparam int TCT_RB_CNT = 5;
  localparam int TCT_RB_STA = 4;

  localparam logic [1:0] TCT_SEL_READBACK = 2'h3;
  localparam logic [15:0] TCT_CNT_ONE     = 16'h0001;
  localparam logic [15:0] TCT_CNT_TWO     = 16'h0002;
  localparam logic [15:0] TCT_CNT_ZERO    = 16'h0000;

  // access order field
  typedef enum logic [1:0] {
    TCT_ACC_LATCH = 2'h0,
    TCT_ACC_LSB   = 2'h1,
    TCT_ACC_MSB   = 2'h2,
    TCT_ACC_PAIR  = 2'h3
  } tct_acc_t;

  // decoded operating mode
  typedef enum logic [2:0] {
    TCT_M0 = 3'h0,
    TCT_M1 = 3'h1,
    TCT_M2 = 3'h2,
    TCT_M3 = 3'h3,
    TCT_M4 = 3'h4,
    TCT_M5 = 3'h5
  } tct_mode_t;

  // per-counter configuration
  typedef struct packed {
    tct_acc_t  acc;
    logic [2:0] mode_raw;
    logic      bcd;
  } tct_cfg_t;

  // one host write or read aimed at a counter
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] data;
  } tct_hacc_t;

endpackage

// >>> tct_sync.sv
// three-flop pin synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
module tct_sync #(
  parameter int W = 6
) (
  input  wire logic         mclk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] lvl_o
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // a change counts only when stages two and three agree
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      lvl_o <= '0;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < W; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          lvl_o[i] <= s3_q[i];
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> tct_top.sv
// triple counter timer block with shared-offset map select on the host port
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - when mapped in, offsets 0h-3h reach the counters, not parallel group.
// - any write to Dh maps counters in, parallel group out.
// - a read of Dh maps counters out, parallel group back in.
// - map changes never reset counters or parallel group; counters keep running.
// - three independent 16-bit down counters, counts up to 65535.
// - clock pulse is a count; gate rising edge is a trigger.
// - mode 0 load drives output low until zero, then high.
// - mode 0 counts only after a gate trigger.
// - mode 1 one-shot low pulse after trigger; retrigger reloads.
// - mode 2 divide by N, one clock low each period, gate stops.
// - mode 3 square wave; odd N high (N+1)/2, low (N-1)/2.
// - mode 3 decrements by two through each half, reloading between.
// - mode 4 counts on load, one clock low at zero, gate inhibits.
// - mode 5 counts after gate edge, one clock low at end, retriggerable.
// - setup byte: select, access order, three mode bits, bcd bit 0.
// - select 0-2 picks a counter; 3 means readback command.
// - access 0 latch, 1 low only, 2 high only, 3 low then high.
// - mode bits decode 000,001,X10,X11,100,101 with X ignored.
// - bit 0 picks binary when 0, decimal when 1.
// - latch copies live count into hold register; reads return it.
// - repeat latches ignored until read; pending status read first.
module tct_top
  import tct_pkg::*;
#(
  parameter int NCNT = 3
) (
  input  wire logic             mclk_i,
  input  wire logic             rst_i,
  input  wire logic [3:0]       addr_i,     // host offset
  input  wire logic             wr_i,       // one-cycle write strobe
  input  wire logic             rd_i,       // one-cycle read strobe
  input  wire logic [7:0]       wdata_i,
  input  wire logic [NCNT-1:0]  cnt_clk_i,  // counter clock pins
  input  wire logic [NCNT-1:0]  cnt_gate_i, // counter gate pins
  output logic      [7:0]       rdata_o,    // counter read data
  output logic                  mapped_in_o, // counters own 0h-3h
  output logic                  pio_sel_o,  // access goes to parallel group
  output logic      [NCNT-1:0]  cnt_out_o
);
  import tct_pkg::*;

  // elaboration guard: select and readback decode serve exactly three counters
  if (NCNT != 3) begin : g_bad_ncnt
    $error("tct_top serves exactly three counters");
  end

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [NCNT-1:0] clk_lvl, gate_lvl, clk_prev_q;

  tct_sync #(.W(2*NCNT)) u_sync (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .pin_i  ({cnt_gate_i, cnt_clk_i}),
    .lvl_o  ({gate_lvl, clk_lvl})
  );

  // counter clock rising edge as one-cycle tick
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      clk_prev_q <= '0;
    end else begin
      clk_prev_q <= clk_lvl;
    end
  end
  wire [NCNT-1:0] tick = clk_lvl & ~clk_prev_q;

  // ****************************************
  // map select
  // ****************************************
  logic map_q;
  wire  acc_mapsel = (addr_i == TCT_OFS_MAPSEL);
  wire  low_ofs    = (addr_i <= TCT_OFS_SETUP);
  wire  to_ctr     = map_q & low_ofs;

  // write sets, read clears; nothing else is touched
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      map_q <= 1'b0;
    end else if (acc_mapsel && wr_i) begin
      map_q <= 1'b1;
    end else if (acc_mapsel && rd_i) begin
      map_q <= 1'b0;
    end
  end

  // registered routing flags for the surrounding board logic
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      mapped_in_o <= 1'b0;
      pio_sel_o   <= 1'b0;
    end else begin
      mapped_in_o <= map_q;
      pio_sel_o   <= low_ofs & ~map_q & (wr_i | rd_i);
    end
  end

  // ****************************************
  // setup byte decode
  // ****************************************
  wire       setup_wr = to_ctr & wr_i & (addr_i == TCT_OFS_SETUP);
  wire [1:0] sel      = wdata_i[TCT_SEL_HI:TCT_SEL_LO];
  wire       is_rb    = (sel == TCT_SEL_READBACK);
  wire       is_latch = wdata_i[TCT_ACC_HI:TCT_ACC_LO] == TCT_ACC_LATCH;
  tct_cfg_t  cfg_in;
  assign cfg_in = '{acc:      tct_acc_t'(wdata_i[TCT_ACC_HI:TCT_ACC_LO]),
                    mode_raw: wdata_i[TCT_MOD_HI:TCT_MOD_LO],
                    bcd:      wdata_i[TCT_BCD]};

  logic [7:0] rd_ch [NCNT];
  logic [NCNT-1:0] out_w;

  // ****************************************
  // counter channels
  // ****************************************
  for (genvar g = 0; g < NCNT; g++) begin : g_ch
    wire hit_sel = setup_wr & ~is_rb & (sel == 2'(g));
    wire rb_hit  = setup_wr & is_rb & wdata_i[TCT_MOD_LO + g];
    wire ch_addr = to_ctr & (addr_i == 4'(g));
    tct_hacc_t ha;
    assign ha = '{wr: ch_addr & wr_i, rd: ch_addr & rd_i, data: wdata_i};

    tct_counter u_cnt (
      .mclk_i   (mclk_i),
      .rst_i    (rst_i),
      .tick_i   (tick[g]),
      .gate_i   (gate_lvl[g]),
      .cfg_we_i (hit_sel & ~is_latch),
      .cfg_i    (cfg_in),
      .latch_i  ((hit_sel & is_latch) | (rb_hit & ~wdata_i[TCT_RB_CNT])),
      .stlat_i  (rb_hit & ~wdata_i[TCT_RB_STA]),
      .hacc_i   (ha),
      .rdata_o  (rd_ch[g]),
      .out_o    (out_w[g])
    );
  end

  // read mux; counters answer one cycle after the read strobe
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rdata_o   <= 8'h00;
      cnt_out_o <= '1;
    end else begin
      rdata_o   <= (to_ctr && rd_i && addr_i <= TCT_OFS_CNT2) ? rd_ch[addr_i[1:0]]
                                                                : rdata_o;
      cnt_out_o <= out_w;  // keeps running while mapped out
    end
  end

  map_in_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (acc_mapsel && wr_i) |=> map_q) else $error("write to map select missed");
  map_out_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (acc_mapsel && rd_i && !wr_i) |=> !map_q) else $error("read of map select missed");
  map_hold_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (!acc_mapsel || !(wr_i || rd_i)) |=> $stable(map_q))
    else $error("map changed without access");
  pio_route_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (map_q && low_ofs && rd_i) |=> !pio_sel_o) else $error("shared offset misrouted");
  out_follow_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    1'b1 |=> cnt_out_o == $past(out_w)) else $error("output not from counter");
endmodule
`default_nettype wire

// >>> test_tct_top.sv
// self-checking bench for the triple counter timer block
`timescale 1ns/10ps
`default_nettype none
// compare two values, count and report
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fail_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_tct_top;
  import tct_pkg::*;
  logic       mclk_i   = 1'b0;
  logic       rst_i    = 1'b1;
  logic [2:0] cnt_clk  = 3'h0;
  logic [2:0] cnt_gate = 3'h0;
  logic [3:0] addr;
  logic       wr;
  logic       rd;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [7:0] b;
  logic       mapped;
  logic       pio_sel;
  logic [2:0] cnt_out;
  int         fail_count = 0;
  int         checks     = 0;
  int         lows;
  // 20 MHz clock
  always #25 mclk_i = ~mclk_i;
  tct_host_model i_host (
    .mclk_i  (mclk_i),
    .rdata_i (rdata),
    .addr_o  (addr),
    .wr_o    (wr),
    .rd_o    (rd),
    .wdata_o (wdata)
  );
  tct_top #(.NCNT(3)) i_dut (
    .mclk_i      (mclk_i),
    .rst_i       (rst_i),
    .addr_i      (addr),
    .wr_i        (wr),
    .rd_i        (rd),
    .wdata_i     (wdata),
    .cnt_clk_i   (cnt_clk),
    .cnt_gate_i  (cnt_gate),
    .rdata_o     (rdata),
    .mapped_in_o (mapped),
    .pio_sel_o   (pio_sel),
    .cnt_out_o   (cnt_out)
  );
  // n counter clock pulses of 20 mclk; output sampled mid-period
  // because the pin path adds some 6 cycles of lag
  task automatic pulse(input int ch, input int n);
    lows = 0;
    repeat (n) begin
      @(posedge mclk_i);
      #1;
      cnt_clk[ch] = 1'b1;
      repeat (10) @(posedge mclk_i);
      #1;
      cnt_clk[ch] = 1'b0;
      repeat (5) @(posedge mclk_i);
      #1;
      if (cnt_out[ch] === 1'b0) lows++;
      repeat (4) @(posedge mclk_i);
    end
  endtask
  // gate level change, then room for the synchroniser
  task automatic gate(input int ch, input logic v);
    @(posedge mclk_i);
    #1;
    cnt_gate[ch] = v;
    repeat (6) @(posedge mclk_i);
  endtask
  task automatic t_map();
    `CHK(cnt_out, 3'h7);
    `CHK(mapped, 1'b0);
    i_host.wr8(TCT_OFS_MAPSEL, 8'h5a);
    @(posedge mclk_i);
    #1;
    `CHK(mapped, 1'b1);
    i_host.rd8(TCT_OFS_CNT0, b);
    `CHK(pio_sel, 1'b0);
    i_host.rd8(TCT_OFS_MAPSEL, b);
    @(posedge mclk_i);
    #1;
    `CHK(mapped, 1'b0);
    i_host.rd8(4'h1, b);
    `CHK(pio_sel, 1'b1);
    i_host.wr8(TCT_OFS_MAPSEL, 8'h00);
    $display("map test done");
  endtask
  task automatic t_mode0();
    i_host.setup(2'h0, 2'h1, 3'h0, 1'b0);
    i_host.wr8(TCT_OFS_CNT0, 8'h03);
    repeat (3) @(posedge mclk_i);
    `CHK(cnt_out[0], 1'b0);
    pulse(0, 6);
    `CHK(cnt_out[0], 1'b0);
    gate(0, 1'b1);
    pulse(0, 6);
    `CHK(cnt_out[0], 1'b1);
    gate(0, 1'b0);
    $display("mode 0 test done");
  endtask
  task automatic t_latch();
    i_host.setup(2'h0, 2'h3, 3'h2, 1'b0);
    i_host.load16(TCT_OFS_CNT0, 16'h1234);
    pulse(0, 2);
    i_host.wr8(TCT_OFS_SETUP, 8'h00);
    i_host.rd8(TCT_OFS_CNT0, b);
    `CHK(b, 8'h34);
    i_host.rd8(TCT_OFS_CNT0, b);
    `CHK(b, 8'h12);
    i_host.wr8(TCT_OFS_SETUP, 8'h00);
    gate(0, 1'b1);
    pulse(0, 3);
    i_host.wr8(TCT_OFS_SETUP, 8'h00);
    i_host.rd8(TCT_OFS_CNT0, b);
    `CHK(b, 8'h34);
    i_host.rd8(TCT_OFS_CNT0, b);
    `CHK(b, 8'h12);
    gate(0, 1'b0);
    // readback: latch count and status of counter 0
    i_host.wr8(TCT_OFS_SETUP, 8'hc2);
    i_host.rd8(TCT_OFS_CNT0, b);
    `CHK(b & 8'h3f, 8'h34);
    i_host.rd8(TCT_OFS_CNT0, b);
    `CHK(b, 8'h32);
    i_host.rd8(TCT_OFS_CNT0, b);
    `CHK(b, 8'h12);
    // high byte only: latched and live reads both give the upper byte
    i_host.setup(2'h0, 2'h2, 3'h4, 1'b0);
    i_host.wr8(TCT_OFS_CNT0, 8'h02);
    pulse(0, 1);
    i_host.wr8(TCT_OFS_SETUP, 8'h00);
    i_host.rd8(TCT_OFS_CNT0, b);
    `CHK(b, 8'h02);
    i_host.rd8(TCT_OFS_CNT0, b);
    `CHK(b, 8'h02);
    $display("latch test done");
  endtask
  task automatic t_mode2();
    i_host.setup(2'h1, 2'h1, 3'h6, 1'b0);
    i_host.wr8(4'h1, 8'h04);
    gate(1, 1'b1);
    pulse(1, 1);
    pulse(1, 12);
    `CHK(lows, 3);
    gate(1, 1'b0);
    pulse(1, 8);
    `CHK(lows, 0);
    $display("mode 2 test done");
  endtask
  task automatic t_mode3();
    i_host.setup(2'h2, 2'h1, 3'h7, 1'b1);
    i_host.wr8(TCT_OFS_CNT2, 8'h05);
    gate(2, 1'b1);
    pulse(2, 2);
    // run mapped out: the square wave must carry on regardless
    i_host.rd8(TCT_OFS_MAPSEL, b);
    pulse(2, 20);
    `CHK(lows, 8);
    `CHK(mapped, 1'b0);
    i_host.wr8(TCT_OFS_MAPSEL, 8'h00);
    i_host.wr8(TCT_OFS_SETUP, 8'he8);
    i_host.rd8(TCT_OFS_CNT2, b);
    `CHK(b & 8'h3f, 8'h1f);
    $display("mode 3 test done");
  endtask
  task automatic t_strobes();
    i_host.setup(2'h1, 2'h1, 3'h1, 1'b0);
    i_host.wr8(4'h1, 8'h03);
    pulse(1, 2);
    gate(1, 1'b1);
    pulse(1, 8);
    `CHK(lows, 3);
    i_host.setup(2'h1, 2'h1, 3'h4, 1'b0);
    i_host.wr8(4'h1, 8'h03);
    pulse(1, 8);
    `CHK(lows, 1);
    i_host.setup(2'h1, 2'h1, 3'h5, 1'b0);
    gate(1, 1'b0);
    i_host.wr8(4'h1, 8'h03);
    pulse(1, 6);
    `CHK(lows, 0);
    gate(1, 1'b1);
    pulse(1, 8);
    `CHK(lows, 1);
    $display("strobe modes test done");
  endtask
  // verdict, the only place the run ends
  task automatic close_out();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // watchdog: tests need about 2000 cycles
  initial begin
    repeat (20000) @(posedge mclk_i);
    fail_count++;
    $display("watchdog expired");
    close_out();
  end
  // main sequence
  initial begin
    repeat (5) @(posedge mclk_i);
    #1;
    rst_i = 1'b0;
    t_map();
    t_mode0();
    t_latch();
    t_mode2();
    t_mode3();
    t_strobes();
    close_out();
  end
endmodule
`default_nettype wire
